// ### meter_cfg_pkg.sv
// Purpose: Shared constants and types for the panel meter switch block
// Assumes: 100 MHz clock, classic Wishbone register access
// Notes: Parameter memory also lives in this file
// ============================================================
// Package
// ============================================================
package meter_cfg_pkg;
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_W = 24;
    localparam int ACC_W = 32;
    localparam int PMEM_DEPTH = 8;
    localparam int PMEM_AW = 3;
    // Parameter memory addresses of the averaging depths
    localparam logic [2:0] AVG_FIRST_ADDR = 3'h2;
    localparam logic [2:0] AVG_SECOND_ADDR = 3'h3;
    localparam logic [2:0] AVG_THIRD_ADDR = 3'h4;
    localparam logic [7:0] AVG_DEPTH_RST = 8'h08;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] OFFSET_OFS = 8'h08;
    localparam logic [7:0] READING_OFS = 8'h0c;
    localparam logic [7:0] INTEG_OFS = 8'h10;
    localparam logic [7:0] PMEM_OFS = 8'h40;
    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LABEL_LSB = 8;
    localparam logic [7:0] LABEL_SPACE = 8'h20;
    localparam logic [7:0] LABEL_RST = 8'h20;
    // Digit counts
    localparam logic [2:0] DIGITS_7 = 3'h7;
    localparam logic [2:0] DIGITS_6 = 3'h6;
    localparam logic [2:0] DIGITS_5 = 3'h5;
    localparam logic [2:0] DIGITS_4 = 3'h4;
    // Integration times in microseconds, code 000 to 111
    localparam int INTEG_US [8] = '{16667, 33333, 50000, 66667,
                                    100000, 166667, 200000, 300000};

    typedef enum logic [1:0] {MODE_REF, MODE_RATIO, MODE_DISPLAY} mode_t;

    typedef struct packed {
        logic tare_master;
        logic offset_capture;
        logic blank_sel_lo;
        logic blank_sel_hi;
        logic avg_sel_lo;
        logic avg_sel_hi;
        logic integ_sel_msb;
        logic integ_sel_mid;
        logic integ_sel_lsb;
    } switches_t;

    typedef struct packed {
        logic [2:0] digits_shown;
        logic show_zero;
        logic integ_enable;
        logic [2:0] integ_code;
    } display_cfg_t;
endpackage

// ============================================================
// Parameter memory, one write port and two registered read ports
// ============================================================
`timescale 1ns/1ps
module param_mem
    import meter_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [PMEM_AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [PMEM_AW-1:0] raddr_a_i,
    output logic [7:0] rdata_a_o,
    input wire logic [PMEM_AW-1:0] raddr_b_i,
    output logic [7:0] rdata_b_o
);
    logic [7:0] mem_q [PMEM_DEPTH];

    genvar g;
    generate
        for (g = 0; g < PMEM_DEPTH; g++)
        begin : g_word
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    mem_q[g] <= AVG_DEPTH_RST;
                else if (we_i && waddr_i == PMEM_AW'(g))
                    mem_q[g] <= wdata_i;
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_a_o <= 8'h00;
            rdata_b_o <= 8'h00;
        end
        else
        begin
            rdata_a_o <= mem_q[raddr_a_i];
            rdata_b_o <= mem_q[raddr_b_i];
        end
    end
endmodule

// ### panel_meter_switch_config.sv
// Purpose: Switch-driven configuration and sample averaging of a panel meter
// Assumes: Switch pins asynchronous; samples arrive on clk_i
// Notes: Registers over classic Wishbone, 32-bit data
// ============================================================
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module panel_meter_switch_config
    import meter_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire meter_cfg_pkg::switches_t switches_i,
    input wire logic sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    output logic reading_valid_o,
    output logic signed [SAMPLE_W-1:0] reading_o,
    output meter_cfg_pkg::display_cfg_t display_cfg_o,
    output logic [31:0] integ_time_us_o
);
    import meter_cfg_pkg::*;

    // ============================================================
    // Switch synchroniser
    // ============================================================
    switches_t sw_meta_q;
    switches_t sw_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sw_meta_q <= '0;
            sw_q <= '0;
        end
        else
        begin
            sw_meta_q <= switches_i;
            sw_q <= sw_meta_q;
        end
    end

    // ============================================================
    // Registers
    // ============================================================
    mode_t mode_q;
    logic [7:0] label_lead_q;
    logic pend_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic signed [SAMPLE_W-1:0] offset_q;
    logic [7:0] bus_rdata;
    logic [7:0] depth_rdata;
    logic pmem_hit;
    logic wr_fire;
    logic [PMEM_AW-1:0] depth_addr;

    assign pmem_hit = wb_adr_i[7:5] == PMEM_OFS[7:5];
    assign wr_fire = ack_q && wb_cyc_i && wb_stb_i && wb_we_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else
        begin
            pend_q <= wb_cyc_i && wb_stb_i && !pend_q && !ack_q;
            ack_q <= pend_q;
        end
    end

    assign wb_ack_o = ack_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= MODE_REF;
            label_lead_q <= LABEL_RST;
        end
        else if (wr_fire && wb_adr_i == CTRL_OFS)
        begin
            if (wb_sel_i[0] && wb_dat_i[CTRL_MODE_LSB +: 2] != 2'h3)
                mode_q <= mode_t'(wb_dat_i[CTRL_MODE_LSB +: 2]);
            if (wb_sel_i[1])
                label_lead_q <= wb_dat_i[CTRL_LABEL_LSB +: 8];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_q <= 32'h0000_0000;
        else if (pend_q && !wb_we_i)
        begin
            if (pmem_hit)
                dat_q <= {24'h00_0000, bus_rdata};
            else
            begin
                unique case (wb_adr_i)
                    CTRL_OFS: dat_q <= {16'h0000, label_lead_q, 6'h00, mode_q};
                    STATUS_OFS: dat_q <= {15'h0000, display_cfg_o, sw_q};
                    OFFSET_OFS: dat_q <= 32'(offset_q);
                    READING_OFS: dat_q <= 32'(reading_o);
                    INTEG_OFS: dat_q <= integ_time_us_o;
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_dat_o = dat_q;

    // Averaging depth address from selects, in every mode
    always_comb
    begin
        unique case ({sw_q.avg_sel_hi, sw_q.avg_sel_lo})
            2'b01: depth_addr = AVG_FIRST_ADDR;
            2'b10: depth_addr = AVG_SECOND_ADDR;
            2'b11: depth_addr = AVG_THIRD_ADDR;
            default: depth_addr = AVG_FIRST_ADDR;
        endcase
    end

    param_mem u_pmem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_fire && pmem_hit && wb_sel_i[0]),
        .waddr_i(wb_adr_i[2 +: PMEM_AW]),
        .wdata_i(wb_dat_i[7:0]),
        .raddr_a_i(wb_adr_i[2 +: PMEM_AW]),
        .rdata_a_o(bus_rdata),
        .raddr_b_i(depth_addr),
        .rdata_b_o(depth_rdata)
    );

    // ============================================================
    // Averager
    // ============================================================
    logic avg_off_q;
    logic [2:0] shift_q;
    logic [2:0] shift_d;
    logic [7:0] count_q;
    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] avg_full;
    logic last;
    logic [2:0] depth_log;

    // Only single-bit depths are legal; anything else passes samples
    always_comb
    begin
        depth_log = 3'h0;
        for (int i = 0; i < 8; i++)
            if (depth_rdata == 8'(1 << i))
                depth_log = 3'(i);
    end

    assign shift_d = (!sw_q.avg_sel_lo && !sw_q.avg_sel_hi) ? 3'h0 : depth_log;
    assign sum = acc_q + ACC_W'(sample_i);
    assign last = count_q == ((8'h01 << shift_q) - 8'h01);
    assign avg_full = sum >>> shift_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_q <= '0;
            count_q <= 8'h00;
            shift_q <= 3'h0;
            avg_off_q <= 1'b1;
        end
        else if (sample_valid_i)
        begin
            if (last)
            begin
                acc_q <= '0;
                count_q <= 8'h00;
                shift_q <= shift_d;
                avg_off_q <= shift_d == 3'h0;
            end
            else
            begin
                acc_q <= sum;
                count_q <= count_q + 8'h01;
            end
        end
    end

    // ============================================================
    // Tare and display settings
    // ============================================================
    logic tare_on;
    logic capture;
    logic signed [SAMPLE_W-1:0] avg_val;
    logic [2:0] digits_d;
    logic label_seven;

    assign avg_val = avg_full[SAMPLE_W-1:0];
    assign tare_on = mode_q == MODE_RATIO && sw_q.tare_master;
    assign capture = tare_on && sw_q.offset_capture;
    assign label_seven = label_lead_q == LABEL_SPACE;

    always_comb
    begin
        unique case ({sw_q.blank_sel_hi, sw_q.blank_sel_lo})
            2'b00: digits_d = label_seven ? DIGITS_7 : DIGITS_6;
            2'b01: digits_d = DIGITS_6;
            2'b10: digits_d = DIGITS_5;
            default: digits_d = DIGITS_4;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            offset_q <= '0;
        else if (sample_valid_i && last && capture)
            offset_q <= avg_val;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reading_valid_o <= 1'b0;
            reading_o <= '0;
        end
        else
        begin
            reading_valid_o <= sample_valid_i && last;
            if (sample_valid_i && last)
            begin
                if (capture)
                    reading_o <= '0;
                else if (tare_on)
                    reading_o <= avg_val - offset_q;
                else
                    reading_o <= avg_val;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            display_cfg_o <= '{digits_shown: DIGITS_7, show_zero: 1'b0,
                               integ_enable: 1'b1, integ_code: 3'h0};
            integ_time_us_o <= 32'(INTEG_US[0]);
        end
        else if (sample_valid_i && last)
        begin
            display_cfg_o.digits_shown <= digits_d;
            display_cfg_o.show_zero <= capture;
            if (mode_q == MODE_DISPLAY)
                display_cfg_o.integ_enable <= 1'b0;
            else
            begin
                display_cfg_o.integ_enable <= 1'b1;
                display_cfg_o.integ_code <= {sw_q.integ_sel_msb, sw_q.integ_sel_mid,
                                             sw_q.integ_sel_lsb};
                integ_time_us_o <= 32'(INTEG_US[{sw_q.integ_sel_msb, sw_q.integ_sel_mid,
                                                 sw_q.integ_sel_lsb}]);
            end
        end
    end

    // ============================================================
    // Assertions
    // ============================================================
    sequence s_result;
        sample_valid_i && last;
    endsequence

    property p_no_tare;
        @(posedge clk_i) disable iff (rst_i)
        s_result and !tare_on |=> reading_o == $past(avg_val);
    endproperty
    a_no_tare: assert property (p_no_tare) else $error("uncorrected reading wrong");

    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        s_result and capture |=> reading_o == '0 && offset_q == $past(avg_val)
            && display_cfg_o.show_zero;
    endproperty
    a_capture: assert property (p_capture) else $error("capture failed");

    property p_subtract;
        @(posedge clk_i) disable iff (rst_i)
        s_result and tare_on && !capture |=> reading_o == $past(avg_val) - offset_q;
    endproperty
    a_subtract: assert property (p_subtract) else $error("offset not subtracted");

    property p_ratio_only;
        @(posedge clk_i) disable iff (rst_i)
        mode_q != MODE_RATIO && $past(mode_q) != MODE_RATIO |-> !tare_on && $stable(offset_q);
    endproperty
    a_ratio_only: assert property (p_ratio_only) else $error("tare outside ratio mode");

    property p_digits;
        @(posedge clk_i) disable iff (rst_i)
        s_result |=> display_cfg_o.digits_shown == ({$past(sw_q.blank_sel_hi),
            $past(sw_q.blank_sel_lo)} == 2'b00 ? ($past(label_seven) ? 3'h7 : 3'h6) :
            3'h7 - {1'b0, $past(sw_q.blank_sel_hi), $past(sw_q.blank_sel_lo)});
    endproperty
    a_digits: assert property (p_digits) else $error("digit count wrong");

    property p_pass;
        @(posedge clk_i) disable iff (rst_i)
        sample_valid_i && avg_off_q |=> reading_valid_o;
    endproperty
    a_pass: assert property (p_pass) else $error("unaveraged sample lost");

    property p_depth;
        @(posedge clk_i) disable iff (rst_i)
        count_q <= (8'h01 << shift_q) - 8'h01;
    endproperty
    a_depth: assert property (p_depth) else $error("averaging count overrun");

    property p_display_mode;
        @(posedge clk_i) disable iff (rst_i)
        s_result and mode_q == MODE_DISPLAY |=> !display_cfg_o.integ_enable
            && $stable(integ_time_us_o);
    endproperty
    a_display_mode: assert property (p_display_mode) else $error("integ not ignored");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !pend_q && !ack_q |=> ##1 wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");
endmodule

// ### switch_bank.sv
// Purpose: Jumper bank that drives the meter's control-input pins
// Assumes: Bench commands the jumper positions on setting_i
// Notes: Positions move one clock after the command
`timescale 1ns/1ps
module switch_bank
    import meter_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire meter_cfg_pkg::switches_t setting_i,
    output meter_cfg_pkg::switches_t switches_o
);
    // ============================================================
    // Jumper positions
    // ============================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            switches_o <= '0;
            switches_o.avg_sel_lo <= 1'b1;
            switches_o.integ_sel_msb <= 1'b1;
        end
        else
        begin
            switches_o <= setting_i;
        end
    end
endmodule

// ### panel_meter_switch_config_tb.sv
// Purpose: Self-checking bench of the panel meter switch block
// Assumes: Registers over classic Wishbone, samples one at a time
// Notes: Each setting is followed by enough idle cycles for the sync
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module panel_meter_switch_config_tb;
    import meter_cfg_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, sv, wb_ack_o, reading_valid_o;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, wb_dat_o, rdat, integ_time_us_o;
    logic signed [SAMPLE_W-1:0] smp, reading_o;
    display_cfg_t display_cfg_o;
    switches_t cmd, sw, s;
    int error_cnt, checks, cyc_cnt;
    int dep[4] = '{1, 2, 4, 128};
    int kk[4] = '{0, 1, 2, 7};
    logic [2:0] exp_d;

    switch_bank bank (.clk_i(clk_i), .rst_i(rst_i), .setting_i(cmd), .switches_o(sw));
    panel_meter_switch_config DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .switches_i(sw), .sample_valid_i(sv),
        .sample_i(smp), .reading_valid_o(reading_valid_o), .reading_o(reading_o),
        .display_cfg_o(display_cfg_o), .integ_time_us_o(integ_time_us_o));

    // ============================================================
    // Clock and timeout
    // ============================================================
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 60000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ============================================================
    // Tasks
    // ============================================================
    task automatic report_and_stop();
        $display("counts checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        `CHK(n, 3)
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic setsw(input switches_t v);
        cmd <= v;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic send(input int v);
        @(posedge clk_i);
        sv <= 1'b1;
        smp <= v[23:0];
        @(posedge clk_i);
        sv <= 1'b0;
    endtask
    // Feeds n samples and checks the one result they make
    task automatic run(input int n, input int k, input int v0, input int dv, input int sub,
                       input logic zero);
        int sum;
        int w;
        sum = 0;
        w = 0;
        for (int i = 0; i < n; i++)
        begin
            send(v0 + i * dv);
            sum += v0 + i * dv;
        end
        do
        begin
            @(posedge clk_i);
            w++;
        end
        while (reading_valid_o !== 1'b1 && w < 20);
        `CHK(reading_valid_o, 1'b1)
        `CHK(reading_o, zero ? 24'h0 : 24'((sum >>> k) - sub))
    endtask

    // ============================================================
    // Tests
    // ============================================================
    initial
    begin
        {cyc, stb, we, sv, adr, wdat, smp, cmd} = '0;
        sel = 4'hf;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rdat, {15'h0, DIGITS_7, 1'b0, 1'b1, 3'h0, 9'h0})
        wb(1'b0, INTEG_OFS, 32'h0);
        `CHK(rdat, 32'(INTEG_US[0]))
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b0, PMEM_OFS + 8'(4 * i), 32'h0);
            `CHK(rdat, 32'h8)
        end
        wb(1'b1, 8'h20, 32'hffff);
        wb(1'b0, 8'h20, 32'h0);
        `CHK(rdat, 32'h0)
        wb(1'b1, READING_OFS, 32'h55);
        wb(1'b0, READING_OFS, 32'h0);
        `CHK(rdat, 32'h0)
        wb(1'b1, CTRL_OFS, 32'h4103);
        wb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rdat, 32'h0000_4100)
        $display("test regs done");
        repeat (8) send(0);
        repeat (5) @(posedge clk_i);
        for (int m = 0; m < 3; m++)
            for (int l = 0; l < 2; l++)
                for (int b = 0; b < 4; b++)
                begin
                    wb(1'b1, CTRL_OFS, {16'h0, (l == 1) ? 8'h41 : LABEL_SPACE, 8'(m)});
                    s = '0;
                    s.blank_sel_lo = b[0];
                    s.blank_sel_hi = b[1];
                    setsw(s);
                    run(1, 0, 100, 0, 0, 1'b0);
                    exp_d = (b == 0) ? ((l == 1) ? DIGITS_6 : DIGITS_7) :
                            (b == 1) ? DIGITS_6 : (b == 2) ? DIGITS_5 : DIGITS_4;
                    `CHK(display_cfg_o.digits_shown, exp_d)
                end
        $display("test blanking done");
        wb(1'b1, CTRL_OFS, 32'h2001);
        s = '0;
        s.tare_master = 1'b1;
        s.offset_capture = 1'b1;
        setsw(s);
        run(1, 0, 500, 0, 0, 1'b1);
        `CHK(display_cfg_o.show_zero, 1'b1)
        wb(1'b0, OFFSET_OFS, 32'h0);
        `CHK(rdat, 32'd500)
        s.offset_capture = 1'b0;
        setsw(s);
        run(1, 0, 800, 0, 500, 1'b0);
        `CHK(display_cfg_o.show_zero, 1'b0)
        run(1, 0, -300, 0, 500, 1'b0);
        s.tare_master = 1'b0;
        s.offset_capture = 1'b1;
        setsw(s);
        run(1, 0, 800, 0, 0, 1'b0);
        wb(1'b1, CTRL_OFS, 32'h2000);
        s.tare_master = 1'b1;
        setsw(s);
        run(1, 0, 700, 0, 0, 1'b0);
        wb(1'b0, OFFSET_OFS, 32'h0);
        `CHK(rdat, 32'd500)
        $display("test tare done");
        wb(1'b1, CTRL_OFS, 32'h2002);
        for (int j = 1; j < 4; j++)
            wb(1'b1, PMEM_OFS + 8'(4 * (j + 1)), 32'(dep[j]));
        for (int j = 1; j < 4; j++)
        begin
            wb(1'b1, CTRL_OFS, 32'(32'h2000 + j - 1));
            s = '0;
            s.avg_sel_lo = j[0];
            s.avg_sel_hi = j[1];
            setsw(s);
            run(1, 0, 9, 0, 0, 1'b0);
            run(dep[j], kk[j], -1000, 37, 0, 1'b0);
            setsw('0);
            run(dep[j], kk[j], 5, -3, 0, 1'b0);
            run(1, 0, -7, 0, 0, 1'b0);
        end
        $display("test averaging done");
        wb(1'b1, CTRL_OFS, 32'h2000);
        for (int c = 0; c < 8; c++)
        begin
            s = '0;
            {s.integ_sel_msb, s.integ_sel_mid, s.integ_sel_lsb} = c[2:0];
            setsw(s);
            run(1, 0, 1, 0, 0, 1'b0);
            `CHK(integ_time_us_o, 32'(INTEG_US[c]))
            `CHK(display_cfg_o.integ_code, c[2:0])
            `CHK(display_cfg_o.integ_enable, 1'b1)
        end
        wb(1'b1, CTRL_OFS, 32'h2002);
        s.integ_sel_msb = 1'b0;
        setsw(s);
        run(1, 0, 1, 0, 0, 1'b0);
        `CHK(display_cfg_o.integ_enable, 1'b0)
        `CHK(display_cfg_o.integ_code, 3'h7)
        `CHK(integ_time_us_o, 32'(INTEG_US[7]))
        $display("test integration done");
        report_and_stop();
    end
endmodule
